// ===== core/awdt_top.sv
// Purpose: Watchdog timer with immediate-reset or interrupt-first response.
// Assumes: Control inputs are on clk_sys_i; no software bus reaches the block.
// Notes:   The counter runs on the system clock, clk_sys_i.
`timescale 1ns/1ps
`default_nettype none
module awdt_top
  import awdt_pkg::*;
#(
  parameter int unsigned BASE_LOG2 = awdt_pkg::RANGE_BASE_LOG2
) (
  input  wire logic                 clk_sys_i,
  input  wire logic                 rst_i,
  input  wire awdt_pkg::awdt_ctrl_t ctrl_i,
  input  wire logic                 irq_clear_i,
  input  wire logic                 kick_i,
  output var  logic                 irq_o,
  output var  logic                 sys_rst_o,
  output var  awdt_pkg::awdt_stat_t stat_o
);
  import awdt_pkg::*;

  initial begin
    if (BASE_LOG2 + NUM_RANGES > CNT_W) $error("BASE_LOG2 too large for counter");
  end

  awdt_state_t      state_q;
  awdt_state_t      state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             irq_q;
  logic             irq_d;
  logic             trig_q;
  logic             trig_d;
  logic             rst_out_q;
  awdt_stat_t       stat_q;
  logic [CNT_W-1:0] preset;
  logic             pulse;
  logic             pulse_done;

  always_comb begin
    preset = (CNT_W'(1) << (BASE_LOG2 + ctrl_i.range_sel)) - CNT_W'(1);
  end

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    irq_d   = irq_q;
    trig_d  = 1'b0;
    case (state_q)
      AWDT_IDLE: begin
        if (ctrl_i.enable) begin
          state_d = AWDT_COUNT;
          cnt_d   = preset;
        end
      end
      AWDT_COUNT: begin
        if (!ctrl_i.enable) begin
          state_d = AWDT_IDLE;
          irq_d   = 1'b0;
        end else if (cnt_q == '0) begin
          if (!ctrl_i.irq_first || irq_q) begin
            trig_d  = 1'b1;
            state_d = AWDT_RESET;
          end else begin
            irq_d = 1'b1;
            cnt_d = preset;
          end
        end else if (irq_clear_i || kick_i) begin
          irq_d = irq_clear_i ? 1'b0 : irq_q;
          cnt_d = preset;
        end else begin
          cnt_d = cnt_q - CNT_W'(1);
        end
      end
      AWDT_RESET: begin
        if (pulse_done) begin
          state_d = AWDT_IDLE;
          irq_d   = 1'b0;
        end
      end
      default: begin
        state_d = AWDT_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_q   <= AWDT_IDLE;
      cnt_q     <= '0;
      irq_q     <= 1'b0;
      trig_q    <= 1'b0;
      rst_out_q <= 1'b0;
      stat_q    <= '0;
    end else begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      irq_q     <= irq_d;
      trig_q    <= trig_d;
      rst_out_q <= pulse;
      stat_q    <= '{irq_pending: irq_d, sys_reset: pulse, count: cnt_d};
    end
  end

  awdt_pulse_gen #(
    .LEN_W (PULSE_W)
  ) u_pulse (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .trig_i    (trig_q),
    .len_i     (ctrl_i.pulse_len),
    .pulse_o   (pulse),
    .done_o    (pulse_done)
  );

  // Outputs straight from flip-flops.
  assign irq_o     = irq_q;
  assign sys_rst_o = rst_out_q;
  assign stat_o    = stat_q;
endmodule
`default_nettype wire

// ===== core/awdt_pkg.sv
// Purpose: Shared constants and types for the watchdog timer block.
// Assumes: Single clock domain at 100 MHz, synchronous active-high reset.
// Notes:   Preset counts are computed from RANGE_BASE_LOG2, one per timeout range.
package awdt_pkg;

  localparam int unsigned CNT_W       = 32;
  localparam int unsigned RANGE_W     = 4;
  localparam int unsigned NUM_RANGES  = 16;
  localparam int unsigned PULSE_W     = 8;
  localparam logic [PULSE_W-1:0] PULSE_DEF = 8'h10;

  // Preset count for range n is 2^(16+n) - 1.
  localparam int unsigned RANGE_BASE_LOG2 = 16;

  // Software-facing control word.
  typedef struct packed {
    logic               enable;
    logic               irq_first;
    logic [RANGE_W-1:0] range_sel;
    logic [PULSE_W-1:0] pulse_len;
  } awdt_ctrl_t;

  // Block status word.
  typedef struct packed {
    logic             irq_pending;
    logic             sys_reset;
    logic [CNT_W-1:0] count;
  } awdt_stat_t;

  typedef enum logic [1:0] {
    AWDT_IDLE  = 2'b00,
    AWDT_COUNT = 2'b01,
    AWDT_RESET = 2'b10
  } awdt_state_t;

endpackage

// ===== core/awdt_pulse_gen.sv
// Purpose: Stretches a trigger into a reset pulse of programmable length.
// Assumes: Trigger is a one-cycle pulse on the same clock.
// Notes:   A zero length is served as one cycle.
`timescale 1ns/1ps
`default_nettype none
module awdt_pulse_gen #(
  parameter int unsigned LEN_W = 8
) (
  input  wire logic             clk_sys_i,
  input  wire logic             rst_i,
  input  wire logic             trig_i,
  input  wire logic [LEN_W-1:0] len_i,
  output var  logic             pulse_o,
  output var  logic             done_o
);
  logic [LEN_W-1:0] cnt_q;
  logic [LEN_W-1:0] cnt_d;
  logic             pulse_q;
  logic             pulse_d;
  logic             done_q;
  logic             done_d;

  initial begin
    if (LEN_W < 1) $error("LEN_W must be at least 1");
  end

  always_comb begin
    cnt_d   = cnt_q;
    pulse_d = pulse_q;
    done_d  = 1'b0;
    if (trig_i && !pulse_q) begin
      pulse_d = 1'b1;
      cnt_d   = (len_i == '0) ? LEN_W'(1) : len_i;
    end else if (pulse_q) begin
      if (cnt_q == LEN_W'(1)) begin
        pulse_d = 1'b0;
        done_d  = 1'b1;
        cnt_d   = '0;
      end else begin
        cnt_d = cnt_q - LEN_W'(1);
      end
    end
  end

  // Registers the pulse state.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cnt_q   <= '0;
      pulse_q <= 1'b0;
      done_q  <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      pulse_q <= pulse_d;
      done_q  <= done_d;
    end
  end

  assign pulse_o = pulse_q;
  assign done_o  = done_q;
endmodule
`default_nettype wire

// ===== tb/awdt_asserts.sv
// Purpose: Port assertions for the watchdog.
// Assumes: One clock, sync active-high reset.
// Notes:   Bound to awdt_top below.
`timescale 1ns/1ps
`default_nettype none
module awdt_asserts
  import awdt_pkg::*;
#(
  parameter int unsigned BASE_LOG2 = 16
) (
  input  wire logic                 clk_sys_i,
  input  wire logic                 rst_i,
  input  wire awdt_pkg::awdt_ctrl_t ctrl_i,
  input  wire logic                 irq_clear_i,
  input  wire logic                 kick_i,
  input  wire logic                 irq_o,
  input  wire logic                 sys_rst_o,
  input  wire awdt_pkg::awdt_stat_t stat_o
);
  // Preset of the selected range and the running condition.
  wire logic [31:0] pre = 32'((64'h1 << (BASE_LOG2 + ctrl_i.range_sel)) - 64'h1);
  wire logic        run = ctrl_i.enable && !sys_rst_o;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  sequence s_load; stat_o.count == pre; endsequence
  sequence s_zero; run && $past(stat_o.count) == 32'h1 && stat_o.count == 32'h0; endsequence
  sequence s_pulse4; sys_rst_o [*4] ##1 !sys_rst_o; endsequence
  AST_LOAD: assert property ($rose(ctrl_i.enable) && !sys_rst_o |=> s_load)
    else $error("preset not loaded");
  AST_DEC: assert property (run && $past(ctrl_i.enable) && stat_o.count > 32'h1 && !irq_clear_i && !kick_i
    |=> stat_o.count == $past(stat_o.count) - 32'h1) else $error("count did not step down");
  AST_ZIRQ: assert property (s_zero and ctrl_i.irq_first && !irq_o |=> irq_o)
    else $error("no interrupt on timeout");
  AST_ZRST: assert property (s_zero and !ctrl_i.irq_first |-> ##[1:4] sys_rst_o)
    else $error("no reset on timeout");
  AST_ESC: assert property (s_zero and ctrl_i.irq_first && irq_o |-> ##[1:4] sys_rst_o)
    else $error("no reset on second timeout");
  AST_PULSE: assert property ($rose(sys_rst_o) && ctrl_i.pulse_len == 8'h04 |-> s_pulse4)
    else $error("reset pulse length wrong");
  AST_CLR: assert property (run && irq_o && irq_clear_i && stat_o.count != 32'h0 |=> !irq_o and s_load)
    else $error("clear did not drop and reload");
  AST_KICK: assert property (run && $past(ctrl_i.enable) && kick_i && !irq_clear_i && stat_o.count != 32'h0
    |=> s_load and irq_o == $past(irq_o)) else $error("kick did not reload");
endmodule
bind awdt_top awdt_asserts #(.BASE_LOG2(BASE_LOG2)) awdt_asserts_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
  .ctrl_i(ctrl_i), .irq_clear_i(irq_clear_i), .kick_i(kick_i), .irq_o(irq_o), .sys_rst_o(sys_rst_o), .stat_o(stat_o));
`default_nettype wire

// ===== tb/tb_awdt_top.sv
// Purpose: Self-checking bench for the watchdog.
// Assumes: BASE_LOG2 of 0, so range r presets 2^r-1.
// Notes:   Drives on rising edges, samples on falling edges.
`timescale 1ns/1ps
`default_nettype none
module tb_awdt_top;
  import awdt_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        rst_i = 1'b1;
  awdt_ctrl_t  ctrl = '0;
  logic        clr = 1'b0;
  logic        kick = 1'b0;
  logic        irq;
  logic        srst;
  logic        s;
  awdt_stat_t  stat;
  int          miscompares = 0;
  int          checked = 0;
  int          cyc = 0;
  int          n;
  int          k;
  logic [35:0] rows [4] = '{36'h1_00000001, 36'h3_00000007, 36'h8_000000FF, 36'hF_00007FFF};
  awdt_top #(.BASE_LOG2(0)) awdt_top_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ctrl_i(ctrl),
    .irq_clear_i(clr), .kick_i(kick), .irq_o(irq), .sys_rst_o(srst), .stat_o(stat));
  // Clock and a hang limit.
  always #5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (miscompares == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    checked++;
    if (!ok) begin
      miscompares++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic cy(input int c);
    repeat (c) @(negedge clk_sys_i);
  endtask
  task automatic drv(input logic en, input logic f, input logic [3:0] r, input logic [7:0] p);
    @(posedge clk_sys_i);
    ctrl <= '{en, f, r, p};
  endtask
  task automatic strobe(input logic c, input logic kk);
    @(posedge clk_sys_i);
    clr <= c;
    kick <= kk;
    @(posedge clk_sys_i);
    clr <= 1'b0;
    kick <= 1'b0;
    cy(1);
  endtask
  // Main sequence: reset, preset table, timeout modes, service.
  initial begin
    repeat (5) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    cy(1);
    chk(irq === 1'b0 && srst === 1'b0 && stat === '0, "reset state");
    foreach (rows[i]) begin
      drv(1'b1, 1'b1, rows[i][35:32], 8'h04);
      cy(2);
      chk(stat.count === rows[i][31:0], "preset");
      drv(1'b0, 1'b1, 4'h0, 8'h04);
      cy(2);
    end
    for (int i = 0; i < 3; i++) begin
      drv(1'b1, i == 1, 4'h2, (i == 2) ? 8'h00 : 8'h04);
      s = 1'b0;
      n = 0;
      k = 0;
      while (srst !== 1'b1 && n < 40) begin
        cy(1);
        s = s | irq;
        n++;
      end
      chk(s === (i == 1) && (i != 1 || irq === 1'b1), "response mode");
      while (srst === 1'b1 && k < 300) begin
        cy(1);
        k++;
      end
      chk(k == ((i == 2) ? 1 : 4), "pulse length");
      drv(1'b0, 1'b0, 4'h2, 8'h04);
      cy(2);
    end
    drv(1'b1, 1'b1, 4'h3, 8'h04);
    n = 0;
    while (irq !== 1'b1 && n < 40) begin
      cy(1);
      n++;
    end
    strobe(1'b0, 1'b1);
    chk(stat.count === 32'h7 && irq === 1'b1, "kick");
    strobe(1'b1, 1'b0);
    chk(stat.count === 32'h7 && irq === 1'b0, "clear");
    print_verdict();
  end
endmodule
`default_nettype wire
